// ===== fmg_pkg.sv
// package: constants for the flash modify guard and read power block
package fmg_pkg;
  // register offsets of the controller (apb byte addresses)
  localparam logic [7:0] REG_PROG_CTL_OFF  = 8'h00;
  localparam logic [7:0] REG_FLASH_TMG_OFF = 8'h04;
  localparam logic [7:0] REG_RST_SRC_OFF   = 8'h08;
  localparam logic [7:0] REG_KEY_OFF    = 8'h0c;
  localparam logic [7:0] REG_CMD_OFF    = 8'h10;
  localparam logic [7:0] REG_STAT_OFF   = 8'h14;
  localparam logic [7:0] REG_IRQS_OFF   = 8'h18;
  localparam logic [7:0] REG_IMSK_OFF   = 8'h1c;
  localparam logic [7:0] REG_PEND_OFF   = 8'h20;
  // program_store_control field positions
  localparam int WR_EN_BIT    = 0;
  localparam int ERASE_EN_BIT = 1;
  localparam int SFLE_BIT   = 2;
  // flash_timing_control bypass bit
  localparam int BYPASS_BIT = 6;
  // reset_source_select field positions
  localparam int POR_FLAG_BIT = 1;
  localparam int FERR_BIT   = 6;
  // supply monitor enable constant; the guard reads the enable from reset_source_select bit 0
  localparam int VMON_BIT   = 8;
  // unlock key values
  localparam logic [7:0] KEY_FIRST  = 8'ha5;
  localparam logic [7:0] KEY_SECOND = 8'hf1;
  // flash geometry
  localparam int ROW_BYTES  = 128;
  localparam int PAGE_BYTES = 1024;
  localparam int ADDR_W     = 16;
  // one-shot width and idle wake limit
  localparam int ONESHOT_NS  = 40;
  localparam int CLK_NS      = 20;
  localparam int ONESHOT_CYC = (ONESHOT_NS + CLK_NS - 1) / CLK_NS;
  localparam int WAKE_CYC    = 3;
  // request opcodes on the link
  typedef enum logic [1:0] {FMG_OP_READ, FMG_OP_WRITE, FMG_OP_IDLE} fmg_op_e;
endpackage : fmg_pkg

// ===== fmg_if.sv
// interface: link between the cpu end and the flash guard end
`timescale 1ns/1ps
interface fmg_if;
  logic        req;
  fmg_pkg::fmg_op_e op;
  logic [15:0] addr;
  logic [7:0]  wdata;
  logic        sfr_we;
  logic [1:0]  sfr_sel;
  logic [7:0]  sfr_wdata;
  logic        ack;
  logic [7:0]  rdata;
  logic [7:0]  prog_ctl;
  logic [7:0]  rst_src;
  logic        busy;
  logic        dev_reset;
  logic        irq_in;
  logic        wake;
  modport dev (input req, op, addr, wdata, sfr_we, sfr_sel, sfr_wdata, irq_in,
               output ack, rdata, prog_ctl, rst_src, busy, dev_reset, wake);
  modport cpu (output req, op, addr, wdata, sfr_we, sfr_sel, sfr_wdata, irq_in,
               input ack, rdata, prog_ctl, rst_src, busy, dev_reset, wake);
endinterface : fmg_if

// ===== fmg_oneshot.sv
// one-shot pulse for the flash sense amplifiers
`timescale 1ns/1ps
module fmg_oneshot (
  // clock and reset
  input  wire logic clk,
  input  wire logic rst_n,
  // control
  input  wire logic access,
  input  wire logic bypass,
  // sense amp enable
  output logic      sa_en
);
  logic [3:0] cnt_q;
  wire  [3:0] cnt_d = access ? 4'(fmg_pkg::ONESHOT_CYC) : (cnt_q != 4'h0 ? cnt_q - 4'h1 : 4'h0);
  // bypass keeps amps on for the whole access; one-shot trims to the minimum
  assign sa_en = bypass ? access : (cnt_q != 4'h0);
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) cnt_q <= 4'h0;
    else        cnt_q <= cnt_d;
  end
endmodule : fmg_oneshot

// ===== fmg_dev.sv
// device end: flash modify guard, key lock, irq hold, read power
`timescale 1ns/1ps
// Contract
// - bad supply monitor write causes fault reset
// - monitor and reset source enabled after por
// - irqs during flash op held till done
// - one-shot drives sense amps minimum time
// - one-shot on at reset, bypass bit six
// - rows of 128 bytes tracked
// - idle wake within three cycles
// - write enable at control bit zero
// - firmware re-enables monitor before write
// - firmware writes reset source fully, por flag set
// - firmware disables irqs around write enable
// - firmware uses internal oscillator during writes
// - unlock a5 then f1, lapses after op
// - erase whole page on write with erase enable
// - fault flag reads one after fault reset
module fmg_dev (
  // clock and reset
  input  wire logic clk,
  input  wire logic rst_n,
  // link to cpu
  fmg_if.dev        lnk,
  // user side
  output logic      sa_en,
  output logic      row_change_q,
  output logic      irq_pend_q
);
  localparam int AW = fmg_pkg::ADDR_W;
  localparam int PG = fmg_pkg::PAGE_BYTES;
  // flash array, two pages deep; only the low eleven address bits reach it
  logic [7:0]    mem [0:2047];
  // control registers seen by firmware
  logic [7:0]    prog_ctl_q;
  logic [7:0]    tmg_q;
  logic [7:0]    rst_src_q;
  logic [7:0]    rdata_q;
  // unlock progress: 0 shut, 1 first key seen, 2 open, 3 locked out
  logic [1:0]    key_q;
  // link answer and fault reset
  logic          ack_q;
  logic          busy_q;
  logic          rst_q;
  // read row tracking
  logic [AW-1:0] last_addr_q;
  // page erase walker
  logic [10:0]   erase_ptr_q;
  logic          erasing_q;
  // idle mode and wake counter
  logic          idle_q;
  logic [1:0]    wake_cnt_q;
  logic          wake_q;
  // register write decode
  wire sel_ps    = lnk.sfr_we && lnk.sfr_sel == 2'd0;
  wire sel_fl    = lnk.sfr_we && lnk.sfr_sel == 2'd1;
  wire sel_rs    = lnk.sfr_we && lnk.sfr_sel == 2'd2;
  wire sel_key   = lnk.sfr_we && lnk.sfr_sel == 2'd3;
  // a read or write request is taken only once the previous one has been answered; an idle request is taken at once
  wire take      = lnk.req && !busy_q && !ack_q;
  wire is_wr     = take && lnk.op == fmg_pkg::FMG_OP_WRITE;
  wire is_rd     = take && lnk.op == fmg_pkg::FMG_OP_READ;
  wire is_idle   = lnk.req && lnk.op == fmg_pkg::FMG_OP_IDLE;
  // control bits
  wire wr_en     = prog_ctl_q[fmg_pkg::WR_EN_BIT];
  wire erase_en  = prog_ctl_q[fmg_pkg::ERASE_EN_BIT];
  wire bypass    = tmg_q[fmg_pkg::BYPASS_BIT];
  // guard is judged in the cycle the write is taken, before any cell moves
  wire mon_ok    = rst_src_q[0] && rst_src_q[fmg_pkg::POR_FLAG_BIT];
  wire guard_ok  = mon_ok && key_q == 2'd2;
  wire flash_wr  = is_wr && wr_en;
  wire fault     = flash_wr && !guard_ok;
  wire do_write  = flash_wr && guard_ok && !erase_en;
  wire do_erase  = flash_wr && guard_ok && erase_en;
  wire erase_end = erasing_q && erase_ptr_q[9:0] == 10'(PG - 1);
  wire wake_due  = idle_q && irq_pend_q && !busy_q;
  wire [10:0] a11 = lnk.addr[10:0];
  // row of an address, used for read-current tracking
  function automatic logic [AW-8:0] row_of(input logic [AW-1:0] a);
    return a[AW-1:7];
  endfunction : row_of
  // control registers; a fault reset restores prog_ctl_q and rst_src_q, with the fault flag set, and keeps tmg_q
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      prog_ctl_q <= 8'h00;
      tmg_q      <= 8'h00;
      rst_src_q  <= 8'h03;
    end else if (rst_q) begin
      prog_ctl_q <= 8'h00;
      rst_src_q  <= 8'h03 | (8'h01 << fmg_pkg::FERR_BIT);
    end else begin
      if (sel_ps) prog_ctl_q <= {5'h00, lnk.sfr_wdata[2:0]};
      if (sel_fl) tmg_q <= lnk.sfr_wdata;
      if (sel_rs) rst_src_q <= {2'b00, lnk.sfr_wdata[5:0]};
    end
  end
  // unlock key: a wrong key locks out until reset, so stray code cannot retry
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      key_q <= 2'd0;
    end else if (rst_q) begin
      key_q <= 2'd0;
    end else if (sel_key) begin
      if (key_q == 2'd0 && lnk.sfr_wdata == fmg_pkg::KEY_FIRST) begin
        key_q <= 2'd1;
      end else if (key_q == 2'd1 && lnk.sfr_wdata == fmg_pkg::KEY_SECOND) begin
        key_q <= 2'd2;
      end else begin
        key_q <= 2'd3;
      end
    end else if (do_write || do_erase) begin
      key_q <= 2'd0;
    end
  end
  // flash array: a write can only clear bits, an erase sets the page to ones
  always_ff @(posedge clk) begin
    if (do_write) begin
      mem[a11] <= mem[a11] & lnk.wdata;
    end else if (erasing_q) begin
      mem[erase_ptr_q] <= 8'hff;
    end
    if (is_rd) begin
      rdata_q <= mem[a11];
    end
  end
  // erase walker; busy holds off new reads and writes for the whole page
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      erasing_q   <= 1'b0;
      erase_ptr_q <= 11'h000;
      busy_q      <= 1'b0;
    end else if (do_erase) begin
      erasing_q   <= 1'b1;
      erase_ptr_q <= {a11[10], 10'h000};
      busy_q      <= 1'b1;
    end else if (erasing_q) begin
      erase_ptr_q <= erase_ptr_q + 11'h001;
      if (erase_end) begin
        erasing_q <= 1'b0;
        busy_q    <= 1'b0;
      end
    end
  end
  // answer: reads and byte writes next edge, an erase only when the page is done
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      ack_q <= 1'b0;
      rst_q <= 1'b0;
    end else begin
      ack_q <= ((is_wr || is_rd) && !fault && !do_erase) || erase_end;
      rst_q <= fault;
    end
  end
  // row tracking: a jump into another row costs extra read current
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      last_addr_q  <= '0;
      row_change_q <= 1'b0;
    end else if (is_rd || is_wr) begin
      last_addr_q  <= lnk.addr;
      row_change_q <= row_of(lnk.addr) != row_of(last_addr_q);
    end
  end
  // irqs seen during a flash operation stay pending until it is over
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      irq_pend_q <= 1'b0;
    end else if (lnk.irq_in) begin
      irq_pend_q <= 1'b1;
    end else if (!busy_q && !wr_en) begin
      irq_pend_q <= 1'b0;
    end
  end
  // idle wake: counted so the resume lands inside the three-cycle bound
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      idle_q     <= 1'b0;
      wake_cnt_q <= 2'd0;
      wake_q     <= 1'b0;
    end else begin
      wake_q <= 1'b0;
      if (is_idle) begin
        idle_q <= 1'b1;
      end
      if (wake_due) begin
        wake_cnt_q <= wake_cnt_q + 2'd1;
        if (wake_cnt_q == 2'(fmg_pkg::WAKE_CYC - 2)) begin
          wake_q     <= 1'b1;
          idle_q     <= 1'b0;
          wake_cnt_q <= 2'd0;
        end
      end
    end
  end
  // sense amp one-shot; bypass trades power for margin at fast clocks
  fmg_oneshot u_os (
    .clk    (clk),
    .rst_n  (rst_n),
    .access (is_rd),
    .bypass (bypass),
    .sa_en  (sa_en)
  );
  // link outputs
  assign lnk.ack       = ack_q;
  assign lnk.rdata     = rdata_q;
  assign lnk.prog_ctl  = prog_ctl_q;
  assign lnk.rst_src   = rst_src_q;
  assign lnk.busy      = busy_q;
  assign lnk.dev_reset = rst_q;
  assign lnk.wake      = wake_q;
endmodule : fmg_dev

// ===== fmg_cpu.sv
// cpu end: apb registers that drive flash requests toward the device
`timescale 1ns/1ps
module fmg_cpu (
  // clock and reset
  input  wire logic        clk,
  input  wire logic        rst_n,
  // apb slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic [31:0]      prdata,
  output logic             pready,
  output logic             pslverr,
  // events
  input  wire logic        irq_src,
  output logic             irq,
  // link
  fmg_if.cpu               lnk
);
  logic [31:0] rdq;
  logic        req_q, sfr_we_q, irq_q;
  logic [1:0]  sel_q, op_q;
  logic [15:0] addr_q;
  logic [7:0]  wd_q, swd_q, last_rd_q;
  // shadow of the timing register, which the link does not carry back
  logic [7:0]  fl_q;
  logic [2:0]  ist_q, imsk_q;
  wire acc  = psel && penable;
  wire wr   = acc && pwrite;
  wire a_ps = paddr == fmg_pkg::REG_PROG_CTL_OFF;
  wire a_fl = paddr == fmg_pkg::REG_FLASH_TMG_OFF;
  wire a_rs = paddr == fmg_pkg::REG_RST_SRC_OFF;
  wire a_ky = paddr == fmg_pkg::REG_KEY_OFF;
  wire a_cm = paddr == fmg_pkg::REG_CMD_OFF;
  wire a_st = paddr == fmg_pkg::REG_STAT_OFF;
  wire a_is = paddr == fmg_pkg::REG_IRQS_OFF;
  wire a_im = paddr == fmg_pkg::REG_IMSK_OFF;
  wire hit  = a_ps | a_fl | a_rs | a_ky | a_cm | a_st | a_is | a_im;
  // events: ack, fault reset, wake
  wire [2:0] ev = {lnk.wake, lnk.dev_reset, lnk.ack};
  // forward register writes to the device; firmware order is software's duty
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      req_q <= 1'b0; sfr_we_q <= 1'b0; sel_q <= 2'd0; op_q <= 2'd0;
      addr_q <= 16'h0000; wd_q <= 8'h00; swd_q <= 8'h00; last_rd_q <= 8'h00;
      fl_q <= 8'h00;
    end else begin
      sfr_we_q <= wr && (a_ps | a_fl | a_rs | a_ky);
      if (wr) begin
        sel_q <= a_fl ? 2'd1 : a_rs ? 2'd2 : a_ky ? 2'd3 : 2'd0;
        swd_q <= pwdata[7:0];
      end
      if (wr && a_cm) begin
        req_q  <= 1'b1;
        op_q   <= pwdata[25:24];
        addr_q <= pwdata[23:8];
        wd_q   <= pwdata[7:0];
      end else if (lnk.ack || lnk.dev_reset || op_q == 2'd2) req_q <= 1'b0;
      if (lnk.ack) last_rd_q <= lnk.rdata;
      if (wr && a_fl) fl_q <= pwdata[7:0];
    end
  end
  // sticky status, write one to clear, set wins
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      ist_q <= 3'h0; imsk_q <= 3'h0; irq_q <= 1'b0;
    end else begin
      ist_q  <= (ist_q & ~((wr && a_is) ? pwdata[2:0] : 3'h0)) | ev;
      if (wr && a_im) imsk_q <= pwdata[2:0];
      irq_q  <= |(ist_q & imsk_q);
    end
  end
  // read mux
  always_comb begin
    rdq = 32'h0000_0000;
    if (a_ps) rdq = {24'h00_0000, lnk.prog_ctl};
    if (a_fl) rdq = {24'h00_0000, fl_q};
    if (a_rs) rdq = {24'h00_0000, lnk.rst_src};
    if (a_cm) rdq = {24'h00_0000, last_rd_q};
    if (a_st) rdq = {29'h0000_0000, lnk.busy, req_q, lnk.dev_reset};
    if (a_is) rdq = {29'h0000_0000, ist_q};
    if (a_im) rdq = {29'h0000_0000, imsk_q};
  end
  // zero-wait apb: pready always high, error on unmapped address
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      prdata <= 32'h0000_0000;
    end else if (psel && !penable) begin
      prdata <= rdq;
    end
  end
  assign pready        = 1'b1;
  assign pslverr       = acc && !hit;
  assign irq           = irq_q;
  assign lnk.req       = req_q;
  assign lnk.op        = fmg_pkg::fmg_op_e'(op_q);
  assign lnk.addr      = addr_q;
  assign lnk.wdata     = wd_q;
  assign lnk.sfr_we    = sfr_we_q;
  assign lnk.sfr_sel   = sel_q;
  assign lnk.sfr_wdata = swd_q;
  assign lnk.irq_in    = irq_src;
endmodule : fmg_cpu

// ===== fmg_sva.sv
// checker: link properties of the flash guard pair
`timescale 1ns/1ps
module fmg_sva (
  // clock and reset
  input wire logic             clk,
  input wire logic             rst_n,
  // link
  input wire logic             req,
  input wire fmg_pkg::fmg_op_e op,
  input wire logic [15:0]      addr,
  input wire logic [7:0]       prog_ctl,
  input wire logic [7:0]       rst_src,
  input wire logic             sfr_we,
  input wire logic             busy,
  input wire logic             dev_reset,
  input wire logic             irq_in,
  input wire logic             wake,
  // device user side
  input wire logic             row_change_q,
  input wire logic             irq_pend_q
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);
  logic [8:0] row_q;
  logic       row_v_q;
  logic       chg_q;
  logic       idle_q;
  logic       req_q;
  wire        rd_req  = req && op == fmg_pkg::FMG_OP_READ;
  // a request stands until answered; only its first cycle is a new access
  wire        new_req = req && !req_q;
  // last row and idle state; a non-read request voids the row history
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      row_q   <= '0;
      row_v_q <= 1'b0;
      chg_q   <= 1'b0;
      idle_q  <= 1'b0;
      req_q   <= 1'b0;
    end else begin
      req_q <= req;
      if (new_req) row_q <= addr[15:7];
      if (new_req) row_v_q <= rd_req;
      if (new_req) chg_q <= addr[15:7] != row_q;
      idle_q <= (req && op == fmg_pkg::FMG_OP_IDLE) || (idle_q && !wake);
    end
  end
  sequence bad_write;
    req && op == fmg_pkg::FMG_OP_WRITE && prog_ctl[0] && rst_src[1:0] != 2'b11;
  endsequence
  a_por_enables: assert property ($rose(rst_n) |-> rst_src[1:0] == 2'b11)
    else $error("monitor off after reset");
  a_fault_bad_mon: assert property (bad_write |-> ##[1:8] dev_reset)
    else $error("no fault reset");
  a_refused_idle: assert property (bad_write |=> !busy)
    else $error("refused write went busy");
  a_fault_flag: assert property ($rose(dev_reset) |-> ##[0:3] rst_src[6])
    else $error("fault flag not set");
  a_irq_held: assert property (busy && irq_in && !irq_pend_q |-> ##[1:2] irq_pend_q)
    else $error("irq not held");
  a_pend_stays: assert property (irq_pend_q && busy |=> irq_pend_q)
    else $error("pending lost while busy");
  a_wake_bound: assert property (idle_q && irq_in |-> ##[0:3] wake)
    else $error("late wake");
  a_ctl_cause: assert property (!$stable(prog_ctl) |-> $past(sfr_we) || $past(dev_reset))
    else $error("control changed uncommanded");
  a_row_track: assert property (rd_req && new_req && row_v_q |=> row_change_q == chg_q)
    else $error("row change wrong");
endmodule : fmg_sva

// ===== tb.sv
// testbench: cpu and device ends joined, driven over apb
`timescale 1ns/1ps
`define CHK(a, b, m) begin checked++; if ((a) !== (b)) begin n_fail++; \
  $display("CHECK FAILED %0t %s", $time, m); end end
module tb;
  logic        clk, rst_n, psel, penable, pwrite, irq_src, pready, err, i0;
  logic        pslverr, irq, sa_en, row_change_q, irq_pend_q;
  logic [7:0]  paddr;
  logic [15:0] a0, a1;
  logic [31:0] pwdata, prdata, rd, seed;
  int          n_fail, checked, n_rst, n_ack, n_wake, n_sa, n, k;
  fmg_if lnk ();
  fmg_cpu u_fmg_cpu (.clk(clk), .rst_n(rst_n), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .irq_src(irq_src), .irq(irq), .lnk(lnk.cpu));
  fmg_dev u_fmg_dev (.clk(clk), .rst_n(rst_n), .lnk(lnk.dev), .sa_en(sa_en),
    .row_change_q(row_change_q), .irq_pend_q(irq_pend_q));
  fmg_sva u_fmg_sva (.clk(clk), .rst_n(rst_n), .req(lnk.req), .op(lnk.op), .addr(lnk.addr),
    .prog_ctl(lnk.prog_ctl), .rst_src(lnk.rst_src), .sfr_we(lnk.sfr_we), .busy(lnk.busy),
    .dev_reset(lnk.dev_reset), .irq_in(lnk.irq_in), .wake(lnk.wake),
    .row_change_q(row_change_q), .irq_pend_q(irq_pend_q));
  // 50 mhz clock
  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end
  // event counters sampled mid-cycle, clear of the edge updates
  always @(negedge clk) begin
    n_rst  += int'(lnk.dev_reset === 1'b1);
    n_ack  += int'(lnk.ack === 1'b1);
    n_wake += int'(lnk.wake === 1'b1);
    n_sa   += int'(sa_en === 1'b1);
  end
  function automatic logic [31:0] xs(input logic [31:0] s);
    s ^= s << 13;
    s ^= s >> 17;
    s ^= s << 5;
    return s;
  endfunction : xs
  task automatic results;
    $display("checked %0d n_fail %0d", checked, n_fail);
    if (n_fail == 0 && checked > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask : results
  // one apb transfer; request held until pready is seen at a rising edge
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int i;
    @(posedge clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    i = 0;
    do begin
      @(posedge clk);
      i++;
    end while (pready !== 1'b1 && i < 20);
    rd = prdata;
    err = pslverr;
    if (i >= 20) begin n_fail++; results(); end
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  // bounded wait for an event counter to reach v; n returns cycles spent
  task automatic wait_ev(ref int c, input int v, input int lim);
    for (n = 0; n < lim && c < v; n++) @(negedge clk);
    if (c < v) begin n_fail++; results(); end
  endtask : wait_ev
  task automatic cmd(input logic [1:0] o, input logic [15:0] a, input logic [7:0] d);
    apb(1'b1, fmg_pkg::REG_CMD_OFF, {6'h00, o, a, d});
  endtask : cmd
  task automatic unlock;
    apb(1'b1, fmg_pkg::REG_KEY_OFF, {24'h00_0000, fmg_pkg::KEY_FIRST});
    apb(1'b1, fmg_pkg::REG_KEY_OFF, {24'h00_0000, fmg_pkg::KEY_SECOND});
  endtask : unlock
  task automatic do_reset;
    rst_n <= 1'b0;
    repeat (4) @(posedge clk);
    rst_n <= 1'b1;
    n_rst = 0;
  endtask : do_reset
  // hang guard
  initial begin
    repeat (100000) @(posedge clk);
    n_fail++;
    results();
  end
  initial begin
    {rst_n, psel, penable, pwrite, irq_src, paddr, pwdata} = '0;
    seed = 32'h0000_0005;
    do_reset();
    @(negedge clk);
    `CHK(lnk.rst_src, 8'h03, "por state")
    apb(1'b0, fmg_pkg::REG_FLASH_TMG_OFF, 32'h0000_0000);
    `CHK(rd[fmg_pkg::BYPASS_BIT], 1'b0, "one-shot on")
    apb(1'b0, 8'h40, 32'h0000_0000);
    `CHK({err, rd}, {1'b1, 32'h0000_0000}, "unmapped")
    $display("test reset done");
    // good write, then a second write without a fresh key
    apb(1'b1, fmg_pkg::REG_IMSK_OFF, 32'h0000_0000);
    apb(1'b1, fmg_pkg::REG_PROG_CTL_OFF, 32'h0000_0001);
    apb(1'b1, fmg_pkg::REG_RST_SRC_OFF, 32'h0000_0003);
    repeat (2) @(negedge clk);
    `CHK(lnk.prog_ctl[fmg_pkg::WR_EN_BIT], 1'b1, "write enable")
    unlock();
    seed = xs(seed);
    cmd(fmg_pkg::FMG_OP_WRITE, seed[15:0], seed[23:16]);
    wait_ev(n_ack, n_ack + 1, 50);
    `CHK(n_rst, 0, "good write")
    cmd(fmg_pkg::FMG_OP_WRITE, seed[15:0], seed[31:24]);
    wait_ev(n_rst, 1, 50);
    apb(1'b0, fmg_pkg::REG_RST_SRC_OFF, 32'h0000_0000);
    `CHK(rd[fmg_pkg::FERR_BIT], 1'b1, "lapse fault")
    $display("test write done");
    do_reset();
    // page erase with an event arriving mid-operation
    apb(1'b1, fmg_pkg::REG_PROG_CTL_OFF, 32'h0000_0003);
    unlock();
    k = n_ack;
    cmd(fmg_pkg::FMG_OP_WRITE, 16'h0400, 8'h00);
    irq_src <= 1'b1;
    repeat (8) @(negedge clk);
    `CHK(irq_pend_q & lnk.busy, 1'b1, "irq held")
    wait_ev(n_ack, k + 1, 1200);
    `CHK(n + 8 >= fmg_pkg::PAGE_BYTES, 1'b1, "erase time")
    @(posedge clk);
    irq_src <= 1'b0;
    apb(1'b1, fmg_pkg::REG_IMSK_OFF, 32'h0000_0001);
    repeat (2) @(negedge clk);
    i0 = irq;
    apb(1'b1, fmg_pkg::REG_IMSK_OFF, 32'h0000_0000);
    repeat (2) @(negedge clk);
    `CHK(i0 ^ irq, 1'b1, "mask gates irq")
    apb(1'b1, fmg_pkg::REG_IRQS_OFF, 32'h0000_0007);
    apb(1'b1, fmg_pkg::REG_IMSK_OFF, 32'h0000_0007);
    repeat (2) @(negedge clk);
    `CHK(irq, 1'b0, "irq cleared")
    $display("test erase done");
    // monitor off, written whole with the por flag kept
    apb(1'b1, fmg_pkg::REG_RST_SRC_OFF, 32'h0000_0002);
    apb(1'b1, fmg_pkg::REG_PROG_CTL_OFF, 32'h0000_0001);
    unlock();
    cmd(fmg_pkg::FMG_OP_WRITE, 16'h0200, 8'h5a);
    wait_ev(n_rst, 1, 50);
    apb(1'b0, fmg_pkg::REG_RST_SRC_OFF, 32'h0000_0000);
    `CHK(rd[fmg_pkg::FERR_BIT], 1'b1, "fault flag")
    $display("test monitor done");
    do_reset();
    // reads across a row boundary, then random; one-shot width per read
    a0 = 16'h007e;
    for (k = 0; k < 9; k++) begin
      seed = xs(seed);
      a1 = (k < 4) ? a0 + 16'h0001 : seed[15:0];
      n_sa = 0;
      cmd(fmg_pkg::FMG_OP_READ, a1, 8'h00);
      repeat (6) @(negedge clk);
      if (k > 0) `CHK(row_change_q, a0 / fmg_pkg::ROW_BYTES != a1 / fmg_pkg::ROW_BYTES, "row")
      `CHK(n_sa inside {[1:fmg_pkg::ONESHOT_CYC]}, 1'b1, "one-shot width")
      a0 = a1;
    end
    apb(1'b1, fmg_pkg::REG_FLASH_TMG_OFF, 32'h0000_0040);
    apb(1'b0, fmg_pkg::REG_FLASH_TMG_OFF, 32'h0000_0000);
    `CHK(rd[fmg_pkg::BYPASS_BIT], 1'b1, "bypass set")
    $display("test read done");
    // idle then wake on an event
    k = n_wake;
    cmd(fmg_pkg::FMG_OP_IDLE, 16'h0000, 8'h00);
    repeat (2) @(posedge clk);
    irq_src <= 1'b1;
    wait_ev(n_wake, k + 1, 8);
    `CHK(n_wake, k + 1, "wake")
    @(posedge clk);
    irq_src <= 1'b0;
    $display("test idle done");
    results();
  end
endmodule : tb
